// [logic/dma_chain_defines.vh]
`ifndef DMA_CHAIN_DEFINES_VH
`define DMA_CHAIN_DEFINES_VH
// configuration word layout
`define CFG_WIDTH 16
`define CFG_DIR_BIT 1
`define CFG_IRQ_EN_BIT 3
`define CFG_SYNC_BIT 5
`define CFG_RESET 16'h0000
// handshake modes
`define HS_MODE_SINGLE 1'b0
`define HS_MODE_BLOCK 1'b1
`endif

// [logic/dma_chain_handshake_control.v]
// Behaviour
// R1: memory space of a work unit comes only from its start address.
// R2: receive chains may change memory space freely, whatever the sync bit.
// R3: transmit unit may change space only if predecessor had sync set.
// R4: write side of memory copy unit follows receive rules.
// R5: controller sets sync bit before read-side space change.
// R6: channel accepts request, urgent request, restart and finish commands.
// R7: urgent request flags need for prompt service.
// R8: restart reloads working address and count from unit start values.
// R9: finish ends unit early, optional interrupt, then starts next unit.
// R10: without handshaking memory copy units run freely.
// R11: two edge-sensitive request inputs, one per memory copy unit.
// R12: with handshaking, requests pass only as edges permit.
// R13: handshake mode: one edge per transfer or one edge per block.
// R14: sync control sits in bit 5 of configuration.
// R15: transmit sync holds unit interrupt until fifo drained.
// R16: peripheral strobes at most one command per cycle.
`include "dma_chain_defines.vh"
module dma_chain_handshake_control #(
  parameter AW = 32,
  parameter CW = 16,
  parameter SPACE_HI = 31,
  parameter SPACE_LO = 28
) (
  // system
  input wire clk_sys,
  input wire sys_rst,
  // descriptor load for the peripheral channel
  input wire desc_valid,
  output wire desc_ready,
  input wire [AW-1:0] desc_start,
  input wire [CW-1:0] desc_count,
  input wire [`CFG_WIDTH-1:0] desc_cfg,
  // peripheral commands, single-cycle strobes
  input wire cmd_request,
  input wire cmd_urgent,
  input wire cmd_restart,
  input wire cmd_finish,
  // memory side of the peripheral channel
  output reg mem_xfer,
  output reg mem_urgent,
  output reg [AW-1:0] mem_addr,
  output reg space_fault,
  input wire fifo_empty,
  // channel status
  output reg unit_done_irq,
  output reg busy,
  output reg [CW-1:0] words_left,
  // memory copy units
  input wire hs_enable_0,
  input wire hs_enable_1,
  input wire hs_mode_0,
  input wire hs_mode_1,
  input wire ext_mdma_request_0,
  input wire ext_mdma_request_1,
  input wire [1:0] copy_req,
  input wire [1:0] copy_block_end,
  output wire [1:0] copy_grant
);

  // channel states; binary codes keep the state register at two bits
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_DRAIN = 2'h2;
  localparam [1:0] ST_NEXT = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [AW-1:0] start_reg;
  reg [AW-1:0] addr_reg;
  reg [CW-1:0] count_start_reg;
  reg [CW-1:0] count_reg;
  reg [`CFG_WIDTH-1:0] cfg_reg;
  reg prev_sync_reg;
  reg [SPACE_HI-SPACE_LO:0] prev_space_reg;
  reg have_prev_reg;
  wire is_tx;
  wire space_change;
  wire space_ok;
  wire [SPACE_HI-SPACE_LO:0] new_space;
  wire xfer;
  wire last;

  assign desc_ready = (state_reg == ST_IDLE) || (state_reg == ST_NEXT);
  assign new_space = desc_start[SPACE_HI:SPACE_LO]; // [R1]
  assign is_tx = desc_cfg[`CFG_DIR_BIT] == 1'b0;
  assign space_change = have_prev_reg && (new_space != prev_space_reg);
  // receive side ignores space change; transmit needs sync on the predecessor
  assign space_ok = !space_change || !is_tx || prev_sync_reg; // [R2] [R3]
  assign xfer = (state_reg == ST_RUN) && (cmd_request || cmd_urgent); // [R6]
  assign last = xfer && (count_reg == {{(CW-1){1'b0}}, 1'b1});

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_NEXT: begin
        if (desc_valid && space_ok) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cmd_finish || last) begin // [R9]
          if (cfg_reg[`CFG_DIR_BIT] == 1'b0 && cfg_reg[`CFG_SYNC_BIT]) begin
            state_next = ST_DRAIN; // [R15]
          end else begin
            state_next = ST_NEXT;
          end
        end
      end
      // transmit with sync waits here so the irq lines up with the peripheral side of the fifo
      ST_DRAIN: begin
        if (fifo_empty) begin
          state_next = ST_NEXT;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      start_reg <= {AW{1'b0}};
      addr_reg <= {AW{1'b0}};
      count_start_reg <= {CW{1'b0}};
      count_reg <= {CW{1'b0}};
      cfg_reg <= `CFG_RESET;
      prev_sync_reg <= 1'b0;
      prev_space_reg <= {(SPACE_HI-SPACE_LO+1){1'b0}};
      have_prev_reg <= 1'b0;
      mem_xfer <= 1'b0;
      mem_urgent <= 1'b0;
      mem_addr <= {AW{1'b0}};
      space_fault <= 1'b0;
      unit_done_irq <= 1'b0;
      busy <= 1'b0;
      words_left <= {CW{1'b0}};
    end else begin
      state_reg <= state_next;
      mem_xfer <= xfer;
      mem_urgent <= xfer && cmd_urgent; // [R7]
      unit_done_irq <= 1'b0;
      // a refused descriptor stays offered; the controller has to withdraw or change it
      space_fault <= desc_valid && desc_ready && !space_ok;
      if (desc_valid && desc_ready && space_ok) begin
        start_reg <= desc_start;
        addr_reg <= desc_start;
        count_start_reg <= desc_count;
        count_reg <= desc_count;
        cfg_reg <= desc_cfg;
        prev_space_reg <= new_space;
        have_prev_reg <= 1'b1;
        prev_sync_reg <= desc_cfg[`CFG_SYNC_BIT]; // [R14]
      // restart rewinds only the working copy, the unit's start values stay
      end else if (state_reg == ST_RUN && cmd_restart) begin
        addr_reg <= start_reg; // [R8]
        count_reg <= count_start_reg;
      end else if (xfer) begin
        mem_addr <= addr_reg;
        addr_reg <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
        count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
      if ((state_reg == ST_RUN || state_reg == ST_DRAIN) && state_next == ST_NEXT) begin
        unit_done_irq <= cfg_reg[`CFG_IRQ_EN_BIT]; // [R9] [R15]
      end
      // busy follows the next state so it rises with the accepting edge
      busy <= state_next != ST_IDLE && state_next != ST_NEXT;
      // status copy only, one cycle behind the working count
      words_left <= count_reg;
    end
  end

  // handshake gates; the copy units' write side needs no space check [R4] [R5]
  wire [1:0] ext_req;
  wire [1:0] hs_en;
  wire [1:0] hs_mode;
  assign ext_req = {ext_mdma_request_1, ext_mdma_request_0}; // [R11]
  assign hs_en = {hs_enable_1, hs_enable_0};
  assign hs_mode = {hs_mode_1, hs_mode_0};

  // one gate per memory copy unit; each sees only its own request pin
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gate
      reg ext_d_reg;
      reg [7:0] credit_reg;
      reg block_open_reg;
      wire edge_seen;
      wire pass;
      assign edge_seen = ext_req[g] && !ext_d_reg; // rising edge only
      // credits count edges so bursts of edges are not lost while a transfer waits
      assign pass = hs_mode[g] == `HS_MODE_BLOCK ? block_open_reg : (credit_reg != 8'h00);
      assign copy_grant[g] = copy_req[g] && (!hs_en[g] || pass); // [R10] [R12]
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          ext_d_reg <= 1'b0;
          credit_reg <= 8'h00;
          block_open_reg <= 1'b0;
        end else begin
          ext_d_reg <= ext_req[g];
          if (!hs_en[g]) begin
            credit_reg <= 8'h00;
            block_open_reg <= 1'b0;
          end else if (hs_mode[g] == `HS_MODE_SINGLE) begin // [R13]
            // credits saturate at 255; edges beyond that are lost
            if (edge_seen && !copy_grant[g] && credit_reg != 8'hff) begin
              credit_reg <= credit_reg + 8'h01;
            end else if (!edge_seen && copy_grant[g]) begin
              credit_reg <= credit_reg - 8'h01;
            end
          end else begin
            if (edge_seen) begin
              block_open_reg <= 1'b1; // [R13]
            end else if (copy_grant[g] && copy_block_end[g]) begin
              block_open_reg <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

endmodule // dma_chain_handshake_control

// [sim/dma_chain_properties.sv]
module dma_props (
  // watched ports
  input wire clk_sys,
  input wire sys_rst,
  input wire desc_valid,
  input wire desc_ready,
  input wire [15:0] desc_cfg,
  input wire cmd_request,
  input wire cmd_urgent,
  input wire cmd_restart,
  input wire mem_xfer,
  input wire mem_urgent,
  input wire space_fault,
  input wire hs_enable_0,
  input wire hs_enable_1,
  input wire [1:0] copy_req,
  input wire [1:0] copy_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_XFER_CAUSE: assert property (mem_xfer |-> $past(cmd_request | cmd_urgent)) else $error("stray xfer");
  AST_URGENT: assert property (mem_urgent |-> mem_xfer && $past(cmd_urgent)) else $error("bad urgent");
  AST_RESTART: assert property (cmd_restart |=> !mem_xfer) else $error("xfer on restart");
  AST_FAULT: assert property (space_fault |-> $past(desc_valid & desc_ready)) else $error("stray fault");
  AST_RX_FREE: assert property (desc_valid & desc_ready & desc_cfg[1] |=> !space_fault) else $error("rx refused");
  AST_FREE_0: assert property (!hs_enable_0 |-> copy_grant[0] == copy_req[0]) else $error("unit0 gated");
  AST_FREE_1: assert property (!hs_enable_1 |-> copy_grant[1] == copy_req[1]) else $error("unit1 gated");
  AST_GATE: assert property ($rose(hs_enable_0) |-> !copy_grant[0]) else $error("unit0 open at enable");
  AST_GATE_1: assert property ($rose(hs_enable_1) |-> !copy_grant[1]) else $error("unit1 open at enable");
  cover property (space_fault);
  cover property (mem_urgent);
  cover property (hs_enable_1 & copy_grant[1]);
endmodule // dma_props

// [sim/fifo_model.sv]
module fifo_model (
  input wire clk_sys,
  input wire sys_rst,
  input wire mem_xfer,
  output logic fifo_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left_reg;
  // drains slowly so an early irq is caught
  always @(posedge clk_sys) begin
    if (sys_rst) left_reg <= 3'h0;
    else if (mem_xfer) left_reg <= 3'h6;
    else if (left_reg != 3'h0) left_reg <= left_reg - 3'h1;
  end
  assign fifo_empty = (left_reg == 3'h0);
endmodule // fifo_model

// [sim/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, sys_rst = 1, desc_valid = 0, cmd_request = 0, cmd_urgent = 0, cmd_restart = 0, cmd_finish = 0;
  logic hs_enable_0 = 0, hs_enable_1 = 0, hs_mode_0 = 0, hs_mode_1 = 0, ext_mdma_request_0 = 0, ext_mdma_request_1 = 0;
  logic [31:0] desc_start = 32'h0, mem_addr;
  logic [15:0] desc_count = 16'h0010, desc_cfg = 16'h0, words_left;
  logic [1:0] copy_req = 2'h0, copy_block_end = 2'h0, copy_grant;
  logic desc_ready, mem_xfer, mem_urgent, space_fault, fifo_empty, unit_done_irq, busy;
  int err_total = 0, cmp_count = 0;
  dma_chain_handshake_control dut (.clk_sys, .sys_rst, .desc_valid, .desc_ready, .desc_start, .desc_count,
    .desc_cfg, .cmd_request, .cmd_urgent, .cmd_restart, .cmd_finish, .mem_xfer, .mem_urgent, .mem_addr,
    .space_fault, .fifo_empty, .unit_done_irq, .busy, .words_left, .hs_enable_0, .hs_enable_1, .hs_mode_0,
    .hs_mode_1, .ext_mdma_request_0, .ext_mdma_request_1, .copy_req, .copy_block_end, .copy_grant);
  fifo_model fm (.clk_sys, .sys_rst, .mem_xfer, .fifo_empty);
  always #20 clk_sys = ~clk_sys;
  task chk(input [39:0] seen, input [39:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task load(input [31:0] a, input [15:0] c);
    desc_start = a;
    desc_cfg = c;
    desc_valid = 1;
    tick(1);
    desc_valid = 0;
  endtask
  task pulse(input [3:0] m);
    {cmd_finish, cmd_restart, cmd_urgent, cmd_request} = m;
    tick(1);
    {cmd_finish, cmd_restart, cmd_urgent, cmd_request} = 4'h0;
  endtask
  task wait_irq(input logic need_empty);
    int n;
    n = 0;
    while (unit_done_irq !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(unit_done_irq, 1, "irq");
    if (need_empty) chk(fifo_empty, 1, "drained");
    tick(2);
  endtask
  task t_recv;
    load(32'h1000_0000, 16'h000a);
    chk(busy, 1, "busy");
    pulse(4'h1);
    chk({mem_xfer, mem_addr}, {1'b1, 32'h1000_0000}, "req");
    tick(1);
    pulse(4'h4);
    chk(mem_xfer, 0, "restart");
    tick(1);
    pulse(4'h2);
    chk({mem_urgent, mem_addr}, {1'b1, 32'h1000_0000}, "reload");
    chk(words_left, 16'h0010, "count");
    tick(1);
    pulse(4'h8);
    wait_irq(0);
    load(32'h2000_0000, 16'h000a);
    chk({busy, space_fault}, 2'h2, "rx space");
    pulse(4'h8);
    wait_irq(0);
  endtask
  task t_xmit;
    load(32'h2000_0100, 16'h0008);
    pulse(4'h1);
    tick(1);
    pulse(4'h8);
    wait_irq(0);
    load(32'h4000_0000, 16'h0008);
    chk({busy, space_fault, desc_ready}, 3'h3, "tx nosync");
    tick(1);
    load(32'h2000_0200, 16'h0028);
    pulse(4'h1);
    tick(1);
    pulse(4'h8);
    wait_irq(1);
    load(32'h4000_0000, 16'h0008);
    chk({busy, space_fault}, 2'h2, "tx sync");
    pulse(4'h8);
    wait_irq(0);
  endtask
  task t_hs;
    copy_req = 2'h3;
    tick(1);
    chk(copy_grant, 2'h3, "free");
    {hs_mode_1, hs_enable_1, hs_enable_0} = 3'h7;
    tick(1);
    chk(copy_grant, 2'h0, "gated");
    {ext_mdma_request_1, ext_mdma_request_0} = 2'h3;
    tick(1);
    chk(copy_grant, 2'h3, "edge");
    tick(1);
    chk(copy_grant, 2'h2, "modes");
    copy_block_end = 2'h2;
    tick(1);
    copy_block_end = 2'h0;
    chk(copy_grant, 2'h0, "block end");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
  initial begin
    tick(20);
    sys_rst = 0;
    t_recv;
    t_xmit;
    t_hs;
    complete_run;
  end
endmodule // tb
bind dma_chain_handshake_control dma_props props_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .desc_valid(desc_valid),
  .desc_ready(desc_ready), .desc_cfg(desc_cfg), .cmd_request(cmd_request), .cmd_urgent(cmd_urgent),
  .cmd_restart(cmd_restart), .mem_xfer(mem_xfer), .mem_urgent(mem_urgent), .space_fault(space_fault),
  .hs_enable_0(hs_enable_0), .hs_enable_1(hs_enable_1), .copy_req(copy_req), .copy_grant(copy_grant));
